//--- src/mei_pkg.sv
package mei_pkg;

  localparam logic [7:0] TAP_SOURCE_ADDR      = 8'h39;
  localparam logic [7:0] ORIENT_SOURCE_ADDR   = 8'h3a;
  localparam logic [7:0] COMBINED_SOURCE_ADDR = 8'h3b;
  localparam logic [7:0] X_OFFSET_ADDR        = 8'h3c;
  localparam logic [7:0] Y_OFFSET_ADDR        = 8'h3d;
  localparam logic [7:0] Z_OFFSET_ADDR        = 8'h3e;
  localparam logic [7:0] CONTROL_ADDR         = 8'h3f;

  localparam logic [7:0] OFFSET_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Control word bit positions.
  localparam int CTL_READY_PULSE   = 7;
  localparam int CTL_MERGE_PINS    = 6;
  localparam int CTL_IRQ_ENABLE    = 5;
  localparam int CTL_OFS_ON_OUTPUT = 4;
  localparam int CTL_OFS_ON_WAKEUP = 3;
  localparam int CTL_OFS_WEIGHT    = 2;
  localparam int CTL_HP_REF        = 1;
  localparam int CTL_ORIENT_FILTER = 0;

  // Offset weights in micro-g per count.
  localparam int OFS_FINE_UG   = 977;
  localparam int OFS_COARSE_UG = 15600;
  // Coarse step expressed as a left shift of the fine step (15.6 mg is about 16 x 977 ug).
  localparam int OFS_COARSE_SHIFT = 4;

  typedef struct packed {
    logic sleep_change;
    logic orient_change;
    logic double_tap;
    logic single_tap;
    logic wakeup;
    logic freefall;
  } mei_events_t;

  typedef struct packed {
    logic       tap_sign;
    logic [2:0] tap_axes;
    logic [5:0] orient_dirs;
  } mei_detail_t;

  typedef struct packed {
    logic ready_pulse_select;
    logic merge_second_pin_to_first;
    logic irq_enable;
    logic offset_on_output;
    logic offset_on_wakeup;
    logic offset_weight_select;
    logic highpass_reference_enable;
    logic orientation_filter_select;
  } mei_ctrl_t;

endpackage

//--- src/mei_offset_apply.sv
`timescale 1ns/10ps
module mei_offset_apply
  import mei_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Offset setup.
  input  wire logic [7:0]               offset,
  input  wire logic                     weight_coarse,
  input  wire logic                     enable,
  // Data path.
  input  wire logic signed [DATA_W-1:0] data_in,
  output logic signed [DATA_W-1:0]      data_out
);
  logic signed [DATA_W-1:0] step;

  // Sign-extend and scale; data is in fine-weight counts so coarse is a shift.
  always_comb begin
    step = DATA_W'(signed'(offset));
    if (weight_coarse) begin
      step = step <<< OFS_COARSE_SHIFT;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= '0;
    end else begin
      data_out <= enable ? DATA_W'(data_in + step) : data_in;
    end
  end
endmodule

//--- src/mei_irq_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - Tap status gives any-tap, single-tap and double-tap flags.
// - Tap status reports sign: 0 positive, 1 negative acceleration.
// - Tap status has one involvement bit each for X, Y and Z.
// - Orientation status flags a detected position change.
// - Orientation status shows six live over-threshold direction flags.
// - Reading the combined source word clears all routed interrupt flags together.
// - Combined word holds sleep change, orientation, double, single, wakeup, freefall.
// - Per-axis eight-bit signed offsets apply to wakeup data.
// - Weight bit picks 977 ug or 15.6 mg per offset count.
// - Offset-on-output adds offsets to output data; host selects low-pass path.
// - Offset-on-wakeup applies offsets only to wakeup data.
// - Data-ready interrupt latched when pulse bit is 0, pulsed when 1.
// - Merge bit copies all second-pin interrupts onto the first pin.
// - High-pass reference mode enabled by control bit, off by default.
// - Orientation input is ODR/2 filtered data, or second low-pass stage.
module mei_irq_ctrl
  import mei_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // Register port from the serial interface.
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  input  wire logic [7:0]                 reg_wdata,
  output logic [7:0]                      reg_rdata,
  // Detection engine events, one-cycle pulses.
  input  wire mei_pkg::mei_events_t       event_pulse,
  input  wire mei_pkg::mei_detail_t       event_detail,
  input  wire logic                       data_ready_pulse,
  // Routing masks of events onto each pin.
  input  wire mei_pkg::mei_events_t       first_pin_route,
  input  wire mei_pkg::mei_events_t       second_pin_route,
  input  wire logic                       ready_on_first,
  input  wire logic                       ready_on_second,
  // Acceleration data per axis.
  input  wire logic signed [3*DATA_W-1:0] accel_in,
  output logic signed [3*DATA_W-1:0]      accel_out,
  output logic signed [3*DATA_W-1:0]      wakeup_data,
  // Filter steering towards the engines.
  output logic                            highpass_reference_enable,
  output logic                            orientation_filter_select,
  // Interrupt pins.
  output logic                            first_interrupt_pin,
  output logic                            second_interrupt_pin
);
  import mei_pkg::*;

  mei_ctrl_t   ctrl;
  logic [7:0]  offset_reg [3];
  mei_events_t event_flags;
  logic [3:0]  tap_detail;
  logic [5:0]  orient_dirs;
  logic        any_tap_flag;
  logic        ready_latched;
  logic        ready_level;
  logic        clear_all;
  logic        raw_first;
  logic        raw_second;
  mei_events_t routed_mask;

  assign clear_all   = reg_read && (reg_addr == COMBINED_SOURCE_ADDR);
  assign routed_mask = first_pin_route | second_pin_route;

  // Control and offset registers.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CONTROL_RESET;
    end else if (reg_write && reg_addr == CONTROL_ADDR) begin
      ctrl <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      offset_reg[0] <= OFFSET_RESET;
      offset_reg[1] <= OFFSET_RESET;
      offset_reg[2] <= OFFSET_RESET;
    end else if (reg_write) begin
      if (reg_addr == X_OFFSET_ADDR) begin
        offset_reg[0] <= reg_wdata;
      end
      if (reg_addr == Y_OFFSET_ADDR) begin
        offset_reg[1] <= reg_wdata;
      end
      if (reg_addr == Z_OFFSET_ADDR) begin
        offset_reg[2] <= reg_wdata;
      end
    end
  end

  assign highpass_reference_enable = ctrl.highpass_reference_enable;
  assign orientation_filter_select = ctrl.orientation_filter_select;

  // Sticky event flags. A new event wins over a clear in the same cycle.
  // Flags not routed to any pin are cleared only by their own read path, which this
  // block does not have, so they stay until reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      event_flags <= '0;
    end else begin
      event_flags <= (clear_all ? (event_flags & ~routed_mask) : event_flags)
                     | event_pulse;
    end
  end

  // Tap detail follows the last tap event; orientation directions are re-sampled every cycle.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tap_detail <= '0;
    end else if (event_pulse.single_tap || event_pulse.double_tap) begin
      tap_detail <= {event_detail.tap_sign, event_detail.tap_axes};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      orient_dirs <= '0;
    end else begin
      orient_dirs <= event_detail.orient_dirs;
    end
  end

  assign any_tap_flag = event_flags.single_tap | event_flags.double_tap;

  // Data-ready: latched until read of the combined word, or a one-cycle pulse.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready_latched <= 1'b0;
    end else if (data_ready_pulse) begin
      ready_latched <= 1'b1;
    end else if (clear_all) begin
      ready_latched <= 1'b0;
    end
  end

  assign ready_level = ctrl.ready_pulse_select ? data_ready_pulse : ready_latched;

  // Register read mux, unused bits zero.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        TAP_SOURCE_ADDR:      reg_rdata <= {1'b0, any_tap_flag, event_flags.single_tap,
                                            event_flags.double_tap, tap_detail};
        ORIENT_SOURCE_ADDR:   reg_rdata <= {1'b0, event_flags.orient_change,
                                            orient_dirs};
        COMBINED_SOURCE_ADDR: reg_rdata <= {2'b00, event_flags};
        X_OFFSET_ADDR:        reg_rdata <= offset_reg[0];
        Y_OFFSET_ADDR:        reg_rdata <= offset_reg[1];
        Z_OFFSET_ADDR:        reg_rdata <= offset_reg[2];
        CONTROL_ADDR:         reg_rdata <= ctrl;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pins, gated by the global enable.
  assign raw_second = (|(event_flags & second_pin_route)) | (ready_on_second & ready_level);
  assign raw_first  = (|(event_flags & first_pin_route)) | (ready_on_first & ready_level)
                    | (ctrl.merge_second_pin_to_first & raw_second);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_interrupt_pin  <= 1'b0;
      second_interrupt_pin <= 1'b0;
    end else begin
      first_interrupt_pin  <= ctrl.irq_enable & raw_first;
      second_interrupt_pin <= ctrl.irq_enable & raw_second;
    end
  end

  // Per-axis offset application. The filter path choice is the host's duty.
  for (genvar a = 0; a < 3; a++) begin : g_axis
    mei_offset_apply #(.DATA_W(DATA_W)) u_out (
      .clk_sys       (clk_sys),
      .reset_n       (reset_n),
      .offset        (offset_reg[a]),
      .weight_coarse (ctrl.offset_weight_select),
      .enable        (ctrl.offset_on_output),
      .data_in       (accel_in[a*DATA_W +: DATA_W]),
      .data_out      (accel_out[a*DATA_W +: DATA_W])
    );
    mei_offset_apply #(.DATA_W(DATA_W)) u_wu (
      .clk_sys       (clk_sys),
      .reset_n       (reset_n),
      .offset        (offset_reg[a]),
      .weight_coarse (ctrl.offset_weight_select),
      .enable        (ctrl.offset_on_wakeup | ctrl.offset_on_output),
      .data_in       (accel_in[a*DATA_W +: DATA_W]),
      .data_out      (wakeup_data[a*DATA_W +: DATA_W])
    );
  end

  // Checks.
  chk_clear_on_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clear_all && !(|(event_pulse & routed_mask))
      |=> !(|(event_flags & routed_mask)))
    else $error("routed flags not cleared by combined read");
  chk_event_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    event_pulse.wakeup |=> event_flags.wakeup)
    else $error("wakeup event lost");
  chk_irq_gate_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ctrl.irq_enable |=> !first_interrupt_pin && !second_interrupt_pin)
    else $error("interrupt pin active while disabled");
  chk_merge_pins: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl.irq_enable && ctrl.merge_second_pin_to_first && raw_second
      |=> first_interrupt_pin)
    else $error("second pin signal missing on first pin");
  chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl.ready_pulse_select && !data_ready_pulse |-> !ready_level)
    else $error("pulsed ready held high");
  chk_ready_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
    data_ready_pulse && !ctrl.ready_pulse_select ##1 !clear_all && !$changed(ctrl)
      |-> ready_level)
    else $error("latched ready dropped");
  chk_src_high_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == COMBINED_SOURCE_ADDR
      |-> reg_rdata[7:6] == 2'b00)
    else $error("unused bits not zero");
  chk_any_tap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    event_pulse.single_tap |=> any_tap_flag)
    else $error("any-tap flag missing");
  chk_tap_sign: assert property (@(posedge clk_sys) disable iff (!reset_n)
    event_pulse.double_tap |=> tap_detail[3] == $past(event_detail.tap_sign))
    else $error("tap sign not captured");

  cov_clear_read:  cover property (@(posedge clk_sys) disable iff (!reset_n) clear_all);
  cov_merge:       cover property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl.merge_second_pin_to_first && raw_second);
  cov_pulse_ready: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl.ready_pulse_select && data_ready_pulse);
endmodule

//--- sim/mei_host_model.sv
`timescale 1ns/10ps
module mei_host_model (
  // Clock.
  input  wire logic       clk_sys,
  // Register port.
  output logic [7:0]      reg_addr,
  output logic            reg_write,
  output logic            reg_read,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Between strobes the bus shows the inverse of the last word, so a
  // design that samples outside its strobe sees wrong values.
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

//--- sim/motion_event_source_and_irq_ctrl_tb_top.sv
`timescale 1ns/10ps
module motion_event_source_and_irq_ctrl_tb_top;
  import mei_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_write, reg_read;
  mei_events_t ev, r1, r2;
  mei_detail_t det;
  logic        drdy, rdy1, rdy2, hp_ref, or_sel, p1, p2;
  logic [47:0] acc, acc_out, wu;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [7:0]  cv[5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14};
  int          ws[5] = '{0, 1, 16, 1, 16};
  int          os[5] = '{0, 0, 0, 1, 16};

  always #25 clk_sys = ~clk_sys;

  mei_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  mei_irq_ctrl dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .event_pulse(ev), .event_detail(det),
    .data_ready_pulse(drdy), .first_pin_route(r1), .second_pin_route(r2),
    .ready_on_first(rdy1), .ready_on_second(rdy2), .accel_in(acc), .accel_out(acc_out),
    .wakeup_data(wu), .highpass_reference_enable(hp_ref),
    .orientation_filter_select(or_sel), .first_interrupt_pin(p1),
    .second_interrupt_pin(p2));

  task automatic complete_run();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // The run takes well under a thousand cycles; the ceiling leaves room.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk({40'h0, d}, {40'h0, e});
  endtask
  task automatic pc(input logic [1:0] e);
    chk({46'h0, p2, p1}, {46'h0, e});
  endtask
  // Events are launched at one edge and taken at the next.
  task automatic pulse(input mei_events_t e, input logic d);
    @(posedge clk_sys);
    ev   <= e;
    drdy <= d;
    @(posedge clk_sys);
    ev   <= '0;
    drdy <= 1'b0;
  endtask
  task automatic route(input mei_events_t a, input mei_events_t b, input logic r);
    @(posedge clk_sys);
    r1   <= a;
    r2   <= b;
    rdy1 <= r;
  endtask
  function automatic logic [47:0] ofs(input int s);
    logic [47:0] r;
    r[15:0]  = 16'(100 + 5 * s);
    r[31:16] = 16'(200 - 5 * s);
    r[47:32] = 16'(300 + 127 * s);
    return r;
  endfunction

  initial begin
    reset_n = 1'b0;
    ev = '0;
    det = '0;
    drdy = 1'b0;
    r1 = '0;
    r2 = '0;
    rdy1 = 1'b0;
    rdy2 = 1'b0;
    acc = ofs(0);
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    rc(CONTROL_ADDR, CONTROL_RESET);
    chk({46'h0, hp_ref, or_sel}, 48'h0);
    for (int i = 0; i < 3; i++) rc(X_OFFSET_ADDR + 8'(i), OFFSET_RESET);
    rc(8'h40, 8'h00);
    host_u.wr(ORIENT_SOURCE_ADDR, 8'hff);
    rc(ORIENT_SOURCE_ADDR, 8'h00);
    host_u.wr(CONTROL_ADDR, 8'h03);
    rc(CONTROL_ADDR, 8'h03);
    chk({46'h0, hp_ref, or_sel}, 48'h3);
    $display("test registers done");
    host_u.wr(CONTROL_ADDR, 8'h20);
    route(6'h3f, 6'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 1'b0);
      @(posedge clk_sys);
      #1;
      pc(2'b01);
      rc(COMBINED_SOURCE_ADDR, 8'h01 << i);
      rc(COMBINED_SOURCE_ADDR, 8'h00);
      pc(2'b00);
    end
    $display("test events done");
    @(posedge clk_sys);
    det <= {1'b1, 3'b101, 6'h2a};
    pulse(6'h04, 1'b0);
    rc(TAP_SOURCE_ADDR, 8'h6d);
    rc(ORIENT_SOURCE_ADDR, 8'h2a);
    pulse(6'h10, 1'b0);
    rc(ORIENT_SOURCE_ADDR, 8'h6a);
    rc(COMBINED_SOURCE_ADDR, 8'h14);
    pulse(6'h08, 1'b0);
    rc(TAP_SOURCE_ADDR, 8'h5d);
    rc(COMBINED_SOURCE_ADDR, 8'h08);
    $display("test status done");
    host_u.wr(CONTROL_ADDR, 8'h00);
    pulse(6'h02, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    pc(2'b00);
    rc(COMBINED_SOURCE_ADDR, 8'h02);
    route(6'h00, 6'h02, 1'b0);
    for (int m = 0; m < 2; m++) begin
      host_u.wr(CONTROL_ADDR, m[0] ? 8'h60 : 8'h20);
      pulse(6'h02, 1'b0);
      @(posedge clk_sys);
      #1;
      pc({1'b1, m[0]});
      rc(COMBINED_SOURCE_ADDR, 8'h02);
    end
    route(6'h00, 6'h00, 1'b1);
    host_u.wr(CONTROL_ADDR, 8'h20);
    pulse(6'h00, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    pc(2'b01);
    rc(COMBINED_SOURCE_ADDR, 8'h00);
    @(posedge clk_sys);
    #1;
    pc(2'b00);
    host_u.wr(CONTROL_ADDR, 8'ha0);
    pulse(6'h00, 1'b1);
    #1;
    pc(2'b01);
    repeat (3) @(posedge clk_sys);
    #1;
    pc(2'b00);
    $display("test pins done");
    host_u.wr(X_OFFSET_ADDR, 8'h05);
    host_u.wr(Y_OFFSET_ADDR, 8'hfb);
    host_u.wr(Z_OFFSET_ADDR, 8'h7f);
    rc(Y_OFFSET_ADDR, 8'hfb);
    for (int k = 0; k < 5; k++) begin
      host_u.wr(CONTROL_ADDR, cv[k]);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(wu, ofs(ws[k]));
      chk(acc_out, ofs(os[k]));
    end
    $display("test offsets done");
    complete_run();
  end
endmodule
